// *** logic/sbp_map.svh ***
/*
 Offsets, field positions, reset values and the wake mask for the dual six-bit port.
 Assumes inclusion by bare name from any design file.
*/
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH
`define SBP_ADDR_STATUS 8'h03
`define SBP_ADDR_PORT1 8'h06
`define SBP_ADDR_PORT2 8'h07
`define SBP_DIR_RESET 6'h3f
`define SBP_OPT_RESET 8'hff
`define SBP_OPT_WAKE_DIS 7
`define SBP_OPT_PULL_DIS 6
`define SBP_OPT_TSRC 5
`define SBP_STAT_WAKE 7
`define SBP_INPUT_ONLY_BIT 3
`define SBP_TIMER_PIN_BIT 5
`define SBP_WAKE_MASK 6'h1b
`endif

// *** logic/sbp_pkg.sv ***
/*
 Types shared by the dual six-bit port files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package sbp_pkg;
  typedef enum logic [1:0] {
    SBP_RUN,
    SBP_SLEEP,
    SBP_WAKE
  } sbp_pwr_t;
  typedef logic [5:0] sbp_bits_t;
endpackage
`default_nettype wire

// *** logic/sbp_pin_ctrl.sv ***
/*
 Per-pin driver and pull-up control for one six-bit port.
 Assumes the caller supplies direction, latch and per-pin overrides.
*/
`include "sbp_map.svh"
`default_nettype none
module sbp_pin_ctrl #(
  parameter int WIDTH = 6
) (
  // Control
  input wire logic [WIDTH-1:0] dir_in,
  input wire logic [WIDTH-1:0] latch_in,
  input wire logic [WIDTH-1:0] no_drive_in,
  input wire logic [WIDTH-1:0] pull_cap_in,
  input wire logic pull_en_in,
  // Pins
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_out,
  output logic [WIDTH-1:0] pullup_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      // Zero drives the latch, one floats
      assign pin_oe_out[i] = ~dir_in[i] & ~no_drive_in[i];
      assign pin_out[i] = latch_in[i];
      // Output pins never pull up
      assign pullup_out[i] = pull_cap_in[i] & pull_en_in & dir_in[i];
    end
  endgenerate
endmodule
`default_nettype wire

// *** logic/sbp_wake_det.sv ***
/*
 Pin-change wake detector for the capable pins of the first port.
 Assumes the last-read snapshot is held by the caller.
*/
`default_nettype none
module sbp_wake_det (
  // Inputs
  input wire logic [5:0] pins_in,
  input wire logic [5:0] snap_in,
  input wire logic [5:0] cap_in,
  input wire logic enable_in,
  // Result
  output logic change_out
);
  assign change_out = enable_in & |((pins_in ^ snap_in) & cap_in);
endmodule
`default_nettype wire

// *** logic/sbp_port.sv ***
/*
 Dual six-bit I/O port with direction registers, shared pull-ups and
 wake-on-change, plus the wake flag of the status register.
 Assumes the CPU core issues one register access per enabled instruction
 cycle and that pins are synchronous to mclk_in.
*/
// Overview of operation
// - Port reads return pin levels, not latches
// - Reset makes every pin a floating input
// - Port one: six pins, top bits zero
// - Port two: six pins, top bits zero
// - Port one bit three is input only
// - Alternate-function pins read as zero
// - Port one bits 0,1,3,4 pull up and wake
// - One global pull-up control, one global wake control
// - Reset-pin mode kills bit three pull-up and wake
// - Direction-load copies working register to direction
// - Direction one floats, zero drives latch
// - Direction registers write-only, reset to ones
// - Port two bit five may follow timer
// - Output latches hold until rewritten
// - Reads sample pins at read time
// - Bit set/clear rewrites whole latch from pins
// - Wake flag set by wake reset only
// - Timer source select takes port two bit five
// - Output pins lose pull-up and wake
// - Option bits seven, six active-low enables
`include "sbp_map.svh"
`default_nettype none
module sbp_port #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Register file access
  input wire logic [7:0] addr_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  // Bit set/clear instructions
  input wire logic bit_op_in,
  input wire logic bit_set_in,
  input wire logic [2:0] bit_sel_in,
  // Direction and option load
  input wire logic dir_load_one_in,
  input wire logic dir_load_two_in,
  input wire logic opt_load_in,
  input wire logic [7:0] work_reg_in,
  // Configuration word and power state
  input wire logic [WIDTH-1:0] alt_one_in,
  input wire logic [WIDTH-1:0] alt_two_in,
  input wire logic ext_reset_mode_in,
  input wire logic sleep_in,
  // Pins of port one
  input wire logic [WIDTH-1:0] port_one_pin_in,
  output logic [WIDTH-1:0] port_one_pin_out,
  output logic [WIDTH-1:0] port_one_oe_out,
  output logic [WIDTH-1:0] port_one_pullup_out,
  // Pins of port two
  input wire logic [WIDTH-1:0] port_two_pin_in,
  output logic [WIDTH-1:0] port_two_pin_out,
  output logic [WIDTH-1:0] port_two_oe_out,
  // Timer and wake
  output logic timer_ext_clock_out,
  output logic timer_source_select_out,
  output logic wake_reset_out,
  output logic wake_on_change_flag_out
);
  logic [WIDTH-1:0] direction_reg_one_q;
  logic [WIDTH-1:0] direction_reg_two_q;
  logic [7:0] timer_config_q;
  logic [WIDTH-1:0] latch_one_q;
  logic [WIDTH-1:0] latch_two_q;
  logic [WIDTH-1:0] snap_one_q;
  logic wake_flag_q;
  logic wake_pend_q;
  logic [7:0] rdata_q;
  sbp_pkg::sbp_pwr_t pwr_q;
  logic [WIDTH-1:0] read_one;
  logic [WIDTH-1:0] read_two;
  logic [WIDTH-1:0] rmw_val;
  logic [WIDTH-1:0] wake_cap;
  logic [WIDTH-1:0] no_drive_one;
  logic [WIDTH-1:0] no_drive_two;
  logic pull_en;
  logic wake_en;
  logic change;
  logic timer_src;
  logic wr_one;
  logic wr_two;
  logic bit_one;
  logic bit_two;

  // Live pin levels, alternate pins masked to zero
  assign read_one = port_one_pin_in & ~alt_one_in;
  assign read_two = port_two_pin_in & ~alt_two_in;

  assign timer_src = timer_config_q[`SBP_OPT_TSRC];
  assign pull_en = ~timer_config_q[`SBP_OPT_PULL_DIS];
  assign wake_en = ~timer_config_q[`SBP_OPT_WAKE_DIS];

  // Capable pins; the reset-pin mode drops bit three
  always_comb begin
    wake_cap = `SBP_WAKE_MASK;
    if (ext_reset_mode_in) begin
      wake_cap[`SBP_INPUT_ONLY_BIT] = 1'b0;
    end
  end

  // Bit three never drives; timer clock overrides bit five
  always_comb begin
    no_drive_one = '0;
    no_drive_one[`SBP_INPUT_ONLY_BIT] = 1'b1;
    no_drive_two = '0;
    no_drive_two[`SBP_TIMER_PIN_BIT] = timer_src;
  end

  assign wr_one = clk_en_in & wr_en_in & (addr_in == `SBP_ADDR_PORT1);
  assign wr_two = clk_en_in & wr_en_in & (addr_in == `SBP_ADDR_PORT2);
  assign bit_one = clk_en_in & bit_op_in & (addr_in == `SBP_ADDR_PORT1) & (bit_sel_in < 3'h6);
  assign bit_two = clk_en_in & bit_op_in & (addr_in == `SBP_ADDR_PORT2) & (bit_sel_in < 3'h6);

  // Read-modify-write takes pins, not latches
  always_comb begin
    rmw_val = (addr_in == `SBP_ADDR_PORT1) ? read_one : read_two;
    // Bits six and seven have no latch to touch
    if (bit_sel_in < 3'h6) begin
      rmw_val[bit_sel_in] = bit_set_in;
    end
  end

  // Direction registers, write-only
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      direction_reg_one_q <= `SBP_DIR_RESET;
      direction_reg_two_q <= `SBP_DIR_RESET;
    end else if (clk_en_in) begin
      if (dir_load_one_in) begin
        direction_reg_one_q <= work_reg_in[WIDTH-1:0];
      end
      if (dir_load_two_in) begin
        direction_reg_two_q <= work_reg_in[WIDTH-1:0];
      end
    end
  end

  // Timer configuration, also write-only
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      timer_config_q <= `SBP_OPT_RESET;
    end else if (clk_en_in && opt_load_in) begin
      timer_config_q <= work_reg_in;
    end
  end

  // Latches survive reset untouched
  always_ff @(posedge mclk_in) begin
    if (wr_one) begin
      latch_one_q <= wdata_in[WIDTH-1:0];
    end else if (bit_one) begin
      latch_one_q <= rmw_val;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (wr_two) begin
      latch_two_q <= wdata_in[WIDTH-1:0];
    end else if (bit_two) begin
      latch_two_q <= rmw_val;
    end
  end

  // Read data register, port reads upper bits zero, status flag in bit seven
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 8'h00;
    end else if (clk_en_in && rd_en_in) begin
      unique case (addr_in)
        `SBP_ADDR_PORT1: rdata_q <= {2'b00, read_one};
        `SBP_ADDR_PORT2: rdata_q <= {2'b00, read_two};
        `SBP_ADDR_STATUS: rdata_q <= {wake_flag_q, 7'h00};
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign rdata_out = rdata_q;

  // Snapshot of last read for change detect
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      snap_one_q <= '0;
    end else if (clk_en_in && ((rd_en_in && addr_in == `SBP_ADDR_PORT1) || bit_one)) begin
      snap_one_q <= read_one;
    end
  end

  sbp_wake_det u_wake (
    .pins_in(read_one),
    .snap_in(snap_one_q),
    .cap_in(wake_cap & direction_reg_one_q),
    .enable_in(wake_en),
    .change_out(change)
  );

  // Power state and wake reset request
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pwr_q <= sbp_pkg::SBP_RUN;
    end else if (clk_en_in) begin
      unique case (pwr_q)
        sbp_pkg::SBP_RUN: if (sleep_in) pwr_q <= sbp_pkg::SBP_SLEEP;
        sbp_pkg::SBP_SLEEP: if (change) pwr_q <= sbp_pkg::SBP_WAKE;
        sbp_pkg::SBP_WAKE: pwr_q <= sbp_pkg::SBP_WAKE;
        default: pwr_q <= sbp_pkg::SBP_RUN;
      endcase
    end
  end
  assign wake_reset_out = (pwr_q == sbp_pkg::SBP_WAKE);

  // Cause kept through a long reset, so a held reset cannot lose it
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      if (wake_reset_out) begin
        wake_pend_q <= 1'b1;
      end
    end else if (clk_en_in) begin
      wake_pend_q <= wake_reset_out;
    end
  end

  // Flag set only by a wake-caused reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      if (wake_pend_q || wake_reset_out) begin
        wake_flag_q <= 1'b1;
      end else begin
        wake_flag_q <= 1'b0;
      end
    end
  end
  assign wake_on_change_flag_out = wake_flag_q;

  sbp_pin_ctrl #(.WIDTH(WIDTH)) u_one (
    .dir_in(direction_reg_one_q),
    .latch_in(latch_one_q),
    .no_drive_in(no_drive_one),
    .pull_cap_in(wake_cap),
    .pull_en_in(pull_en),
    .pin_out(port_one_pin_out),
    .pin_oe_out(port_one_oe_out),
    .pullup_out(port_one_pullup_out)
  );

  sbp_pin_ctrl #(.WIDTH(WIDTH)) u_two (
    .dir_in(direction_reg_two_q),
    .latch_in(latch_two_q),
    .no_drive_in(no_drive_two),
    .pull_cap_in('0),
    .pull_en_in(1'b0),
    .pin_out(port_two_pin_out),
    .pin_oe_out(port_two_oe_out),
    .pullup_out()
  );

  assign timer_ext_clock_out = timer_src & port_two_pin_in[`SBP_TIMER_PIN_BIT];
  assign timer_source_select_out = timer_src;

  // Checks
  dir_reset_a: assert property (@(posedge mclk_in)
    sys_rst_in |=> port_one_oe_out == '0 && port_two_oe_out == '0)
    else $error("pins drive after reset");
  in_only_a: assert property (@(posedge mclk_in) !port_one_oe_out[`SBP_INPUT_ONLY_BIT])
    else $error("input-only pin driven");
  dir_load_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && dir_load_one_in |=> direction_reg_one_q == $past(work_reg_in[WIDTH-1:0]))
    else $error("direction load lost");
  dir_load_two_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && dir_load_two_in |=> direction_reg_two_q == $past(work_reg_in[WIDTH-1:0]))
    else $error("direction load two lost");
  read_pins_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && rd_en_in && addr_in == `SBP_ADDR_PORT1 |=> rdata_out == {2'b00, $past(read_one)})
    else $error("port read not pin level");
  read_two_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && rd_en_in && addr_in == `SBP_ADDR_PORT2 |=> rdata_out == {2'b00, $past(read_two)})
    else $error("port two read not pin level");
  upper_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && rd_en_in && addr_in == `SBP_ADDR_PORT2 |=> rdata_out[7:6] == 2'b00)
    else $error("upper bits not zero");
  upper_one_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && rd_en_in && addr_in == `SBP_ADDR_PORT1 |=> rdata_out[7:6] == 2'b00)
    else $error("port one upper bits not zero");
  alt_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && rd_en_in && addr_in == `SBP_ADDR_PORT1 |=> (rdata_out[5:0] & $past(alt_one_in)) == '0)
    else $error("alternate pin not zero");
  stat_read_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && rd_en_in && addr_in == `SBP_ADDR_STATUS |=> rdata_out == {$past(wake_flag_q), 7'h00})
    else $error("status read wrong");
  out_no_pull_a: assert property (@(posedge mclk_in) (port_one_pullup_out & ~direction_reg_one_q) == '0)
    else $error("pull-up on output");
  cap_mask_a: assert property (@(posedge mclk_in) (port_one_pullup_out & ~`SBP_WAKE_MASK) == '0)
    else $error("pull-up on incapable pin");
  pull_off_a: assert property (@(posedge mclk_in)
    timer_config_q[`SBP_OPT_PULL_DIS] |-> port_one_pullup_out == '0)
    else $error("pull-up while disabled");
  pull_share_a: assert property (@(posedge mclk_in)
    pull_en && !ext_reset_mode_in |-> port_one_pullup_out == (`SBP_WAKE_MASK & direction_reg_one_q))
    else $error("pull-up not global");
  tmr_pin_a: assert property (@(posedge mclk_in) timer_src |-> !port_two_oe_out[`SBP_TIMER_PIN_BIT])
    else $error("timer pin driven");
  latch_hold_a: assert property (@(posedge mclk_in) !wr_two && !bit_two |=> $stable(latch_two_q))
    else $error("latch changed unwritten");
  latch_one_a: assert property (@(posedge mclk_in) !wr_one && !bit_one |=> $stable(latch_one_q))
    else $error("latch one changed unwritten");
  rmw_a: assert property (@(posedge mclk_in)
    bit_one && !wr_one |=> latch_one_q == $past(rmw_val))
    else $error("bit operation lost");
  freeze_a: assert property (@(posedge mclk_in)
    !clk_en_in && !sys_rst_in |=> $stable(direction_reg_one_q) && $stable(timer_config_q) && $stable(latch_one_q))
    else $error("state moved while frozen");
  reset_pull_a: assert property (@(posedge mclk_in)
    ext_reset_mode_in |-> !port_one_pullup_out[`SBP_INPUT_ONLY_BIT])
    else $error("reset pin pulled up");
  sleep_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && pwr_q == sbp_pkg::SBP_RUN && sleep_in |=> pwr_q == sbp_pkg::SBP_SLEEP)
    else $error("sleep not entered");
  wake_rst_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && pwr_q == sbp_pkg::SBP_SLEEP && change |=> wake_reset_out)
    else $error("pin change did not wake");
  wake_dis_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && pwr_q == sbp_pkg::SBP_SLEEP && !wake_en |=> !wake_reset_out)
    else $error("wake while disabled");
  wake_flag_a: assert property (@(posedge mclk_in)
    sys_rst_in && !wake_pend_q && !wake_reset_out |=> !wake_on_change_flag_out)
    else $error("wake flag without wake");
  wake_set_a: assert property (@(posedge mclk_in) sys_rst_in && wake_reset_out |=> wake_on_change_flag_out)
    else $error("wake flag missed");

  // Main scenarios
  wake_c: cover property (@(posedge mclk_in) pwr_q == sbp_pkg::SBP_SLEEP ##1 wake_reset_out);
  rmw_c: cover property (@(posedge mclk_in) bit_one);
  dir_c: cover property (@(posedge mclk_in) clk_en_in && dir_load_two_in);
  freeze_c: cover property (@(posedge mclk_in) !clk_en_in && wr_en_in);
  flag_c: cover property (@(posedge mclk_in) sys_rst_in && wake_on_change_flag_out);
endmodule
`default_nettype wire

// *** bench/sbp_board.sv ***
/*
 Board model for one six-bit port: external drivers, pull-ups, floating lines.
 Assumes the bench supplies external levels and their enables.
*/
`default_nettype none
module sbp_board (
  // Clock
  input wire logic mclk_in,
  // Device side
  input wire logic [5:0] dev_pin_in,
  input wire logic [5:0] dev_oe_in,
  input wire logic [5:0] pullup_in,
  // Board side
  input wire logic [5:0] ext_val_in,
  input wire logic [5:0] ext_en_in,
  // Resolved level
  output logic [5:0] level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] float_q = 6'h15;
  // Undriven lines wander, so a stale level never reads as valid
  always @(posedge mclk_in) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      level_out[i] = dev_oe_in[i] ? dev_pin_in[i] : ext_en_in[i] ? ext_val_in[i] : pullup_in[i] | float_q[i];
    end
  end
endmodule
`default_nettype wire

// *** bench/six_bit_dual_io_port_tb_top.sv ***
/*
 Self-checking bench for the dual six-bit port.
 Assumes sbp_port and two sbp_board pin models.
*/
`default_nettype none
module six_bit_dual_io_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bop = 1'b0, bset = 1'b0, xr = 1'b0, slp = 1'b0;
  logic [2:0] lds = 3'h0, bsel = 3'h0;
  logic [7:0] addr = 8'h00, wd = 8'h00, work = 8'h00, rdata, v;
  logic [5:0] alt1 = 6'h00, alt2 = 6'h00, e1 = 6'h00, e2 = 6'h00, p1, p2, po1, po2, oe1, oe2, pu, d, q1;
  logic tclk, tsel, wk, flag;
  logic ce = 1'b1;
  logic [31:0] seed = 32'h46;
  int failures = 0, checks_done = 0;
  always #50 mclk = ~mclk;
  sbp_port DUT (.mclk_in(mclk), .sys_rst_in(rst), .clk_en_in(ce), .addr_in(addr), .wr_en_in(wr),
    .rd_en_in(rd), .wdata_in(wd), .rdata_out(rdata), .bit_op_in(bop), .bit_set_in(bset), .bit_sel_in(bsel),
    .dir_load_one_in(lds[0]), .dir_load_two_in(lds[1]), .opt_load_in(lds[2]), .work_reg_in(work),
    .alt_one_in(alt1), .alt_two_in(alt2), .ext_reset_mode_in(xr), .sleep_in(slp),
    .port_one_pin_in(p1), .port_one_pin_out(po1), .port_one_oe_out(oe1), .port_one_pullup_out(pu),
    .port_two_pin_in(p2), .port_two_pin_out(po2), .port_two_oe_out(oe2), .timer_ext_clock_out(tclk),
    .timer_source_select_out(tsel), .wake_reset_out(wk), .wake_on_change_flag_out(flag));
  sbp_board b1 (.mclk_in(mclk), .dev_pin_in(po1), .dev_oe_in(oe1), .pullup_in(pu), .ext_val_in(e1),
    .ext_en_in(6'h3f), .level_out(p1));
  sbp_board b2 (.mclk_in(mclk), .dev_pin_in(po2), .dev_oe_in(oe2), .pullup_in(6'h00), .ext_val_in(e2),
    .ext_en_in(6'h3f), .level_out(p2));
  function automatic logic [5:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[5:0];
  endfunction
  function automatic logic [5:0] pux(logic [1:0] o, logic [5:0] dr, logic x);
    return o[0] ? 6'h00 : 6'h1b & dr & (x ? 6'h37 : 6'h3f);
  endfunction
  function automatic logic [5:0] rmw(logic [5:0] pins, old, logic [2:0] s, logic st);
    if (s > 3'h5) begin
      return old;
    end
    return st ? pins | (6'h01 << s) : pins & ~(6'h01 << s);
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Kind 0 read, 1 write, 2 bit op with set in dat[3] and index in dat[2:0]
  task automatic bus(input int k, input logic [7:0] a, dat);
    @(posedge mclk);
    addr <= a;
    wd <= dat;
    rd <= (k == 0);
    wr <= (k == 1);
    bop <= (k == 2);
    bset <= dat[3];
    bsel <= dat[2:0];
    @(posedge mclk);
    {rd, wr, bop} <= 3'h0;
    #1;
    v = rdata;
  endtask
  task automatic ld(input int w, input logic [7:0] dat);
    @(posedge mclk);
    lds[w] <= 1'b1;
    work <= dat;
    @(posedge mclk);
    lds <= 3'h0;
    #1;
  endtask
  task automatic pulse_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Run needs well under 1000 cycles
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("oe1", {2'h0, oe1}, 8'h00);
    chk("oe2", {2'h0, oe2}, 8'h00);
    chk("pullup", {2'h0, pu}, 8'h00);
    chk("flag", {7'h00, flag}, 8'h00);
    bus(0, 8'h05, 8'h00);
    chk("unmapped", v, 8'h00);
    repeat (6) begin
      @(posedge mclk);
      e1 <= rnd();
      e2 <= rnd();
      bus(0, 8'h06, 8'h00);
      chk("port1", v, {2'h0, e1});
      bus(0, 8'h07, 8'h00);
      chk("port2", v, {2'h0, e2});
    end
    ld(0, 8'h00);
    chk("oe1", {2'h0, oe1}, 8'h37);
    ld(1, 8'h00);
    chk("oe2", {2'h0, oe2}, 8'h1f);
    chk("tclk", {7'h00, tclk}, {7'h00, e2[5]});
    ld(2, 8'h00);
    chk("oe2", {2'h0, oe2}, 8'h3f);
    chk("tsel", {7'h00, tsel}, 8'h00);
    repeat (6) begin
      d = rnd();
      bus(1, 8'h06, {2'h3, d});
      chk("latch1", {2'h0, po1}, {2'h0, d});
      bus(0, 8'h06, 8'h00);
      chk("drive1", v, {2'h0, d & 6'h37 | e1 & 6'h08});
      bus(1, 8'h07, {2'h0, ~d});
      bus(0, 8'h07, 8'h00);
      chk("drive2", v, {2'h0, ~d});
    end
    ld(0, 8'h3f);
    bus(0, 8'h06, 8'h00);
    chk("pins1", v, {2'h0, e1});
    chk("hold1", {2'h0, po1}, {2'h0, d});
    @(posedge mclk);
    ce <= 1'b0;
    bus(1, 8'h06, {2'h0, ~d});
    ld(0, 8'h00);
    ce <= 1'b1;
    chk("frz_latch", {2'h0, po1}, {2'h0, d});
    chk("frz_dir", {2'h0, oe1}, 8'h00);
    q1 = d;
    @(posedge mclk);
    alt1 <= rnd();
    alt2 <= rnd();
    bus(0, 8'h06, 8'h00);
    chk("alt1", v, {2'h0, e1 & ~alt1});
    bus(0, 8'h07, 8'h00);
    chk("alt2", v, {2'h0, ~d & ~alt2});
    {alt1, alt2} <= 12'h000;
    for (int k = 0; k < 8; k++) begin
      d = rnd() | 6'h08;
      @(posedge mclk);
      xr <= k[2];
      ld(2, {k[1:0], 6'h00});
      ld(0, {2'h0, d});
      chk("pullup", {2'h0, pu}, {2'h0, pux(k[1:0], d, k[2])});
    end
    xr <= 1'b0;
    ld(0, 8'h3f);
    for (int s = 0; s < 8; s++) begin
      @(posedge mclk);
      e1 <= rnd();
      d = rnd();
      bus(2, 8'h06, {4'h0, d[0], s[2:0]});
      q1 = rmw(e1, q1, s[2:0], d[0]);
      chk("rmw1", {2'h0, po1}, {2'h0, q1});
    end
    ld(2, 8'h00);
    bus(0, 8'h06, 8'h00);
    @(posedge mclk);
    slp <= 1'b1;
    @(posedge mclk);
    slp <= 1'b0;
    e1 <= e1 ^ 6'h24;
    repeat (4) @(posedge mclk);
    #1;
    chk("nowake", {7'h00, wk}, 8'h00);
    e1 <= e1 ^ 6'h10;
    for (int i = 0; i < 5 && wk !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("wake", {7'h00, wk}, 8'h01);
    pulse_reset();
    chk("flag", {7'h00, flag}, 8'h01);
    bus(0, 8'h03, 8'h00);
    chk("status", v, 8'h80);
    ld(0, 8'h00);
    pulse_reset();
    chk("oe1", {2'h0, oe1}, 8'h00);
    chk("flag", {7'h00, flag}, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
